//--- core/bgc_gate_consts.svh
// Constants shared by the bridge gate control and fault guard block.
`ifndef BGC_GATE_CONSTS_SVH
`define BGC_GATE_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define BGC_PWM_W        9
`define BGC_DEAD_W       8
`define BGC_PRESC_W      8
`define BGC_BRIDGES      4
`define BGC_GROUPS       2

// ----------------------------------------------------------------------
// Reset values and fixed levels
// ----------------------------------------------------------------------
`define BGC_PWM_CNT_RST  9'h000
`define BGC_PRESC_RST    8'h00
`define BGC_DEAD_RST     8'h00
`define BGC_DEAD_ONE     8'h01
`define BGC_CNT_ONE      9'h001
`define BGC_PRESC_ONE    8'h01
`define BGC_FLAG_RST     1'b0
`define BGC_LVL_LOW      1'b0
`define BGC_LVL_HIGH     1'b1

// ----------------------------------------------------------------------
// Bridge positions
// ----------------------------------------------------------------------
`define BGC_BR_Y2        0
`define BGC_BR_Y1_W      1
`define BGC_BR_X2_V      2
`define BGC_BR_X1_U      3

`endif

//--- core/bgc_pkg.sv
// Types shared by the bridge gate control and fault guard block.
package bgc_pkg;

	// One half bridge: both transistors off, one of them on, or dead time.
	typedef enum logic [1:0] {
		BGC_HB_OFF  = 2'b00,
		BGC_HB_HIGH = 2'b01,
		BGC_HB_LOW  = 2'b10,
		BGC_HB_DEAD = 2'b11
	} bgc_hb_state_t;

endpackage

//--- core/bgc_sync2.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps

module bgc_sync2 #(
	parameter int          WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// Reset to the idle level so an active-low pin does not look asserted.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule

//--- core/bgc_half_bridge.sv
// One half bridge with break-before-make dead time.
`timescale 1ns/1ps
`include "bgc_gate_consts.svh"

module bgc_half_bridge (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   bridge_en,
	input  wire logic                   want_high,
	input  wire logic [`BGC_DEAD_W-1:0] dead_time,
	output logic                        high_on,
	output logic                        low_on
);

	bgc_pkg::bgc_hb_state_t state_reg;
	bgc_pkg::bgc_hb_state_t state_next;
	bgc_pkg::bgc_hb_state_t target;
	logic [`BGC_DEAD_W-1:0] dead_reg;
	logic [`BGC_DEAD_W-1:0] dead_next;
	logic [`BGC_DEAD_W-1:0] dead_load;

	// A conducting state is only ever entered through dead time, so an
	// off phase in between cannot shorten the gap between the two switches.
	always_comb begin
		target     = !bridge_en ? bgc_pkg::BGC_HB_OFF :
		             (want_high ? bgc_pkg::BGC_HB_HIGH : bgc_pkg::BGC_HB_LOW);
		dead_load  = (dead_time == `BGC_DEAD_RST) ? `BGC_DEAD_ONE : dead_time;
		state_next = state_reg;
		dead_next  = dead_reg;
		case (state_reg)
			bgc_pkg::BGC_HB_DEAD: begin
				if (target == bgc_pkg::BGC_HB_OFF) begin
					state_next = bgc_pkg::BGC_HB_OFF;
				end else if (dead_reg <= `BGC_DEAD_ONE) begin
					state_next = target; // see R14
				end else begin
					dead_next = dead_reg - `BGC_DEAD_ONE;
				end
			end
			default: begin
				if (target == bgc_pkg::BGC_HB_OFF) begin
					state_next = bgc_pkg::BGC_HB_OFF;
				end else if (target != state_reg) begin
					state_next = bgc_pkg::BGC_HB_DEAD; // see R14
					dead_next  = dead_load;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= bgc_pkg::BGC_HB_OFF;
			dead_reg  <= `BGC_DEAD_RST;
		end else begin
			state_reg <= state_next;
			dead_reg  <= dead_next;
		end
	end

	assign high_on = (state_reg == bgc_pkg::BGC_HB_HIGH);
	assign low_on  = (state_reg == bgc_pkg::BGC_HB_LOW);

endmodule

//--- core/bgc_gate_ctrl.sv
// Gate control stage: PWM, dead time, polarity, chopping, fault latch, data line share.
`timescale 1ns/1ps
`include "bgc_gate_consts.svh"

// Function
// R1 - Companion select low routes companion data out
// R2 - Both selected: companion data wins on line
// R3 - Host selects only one device at once
// R4 - Polarity inputs set high and low gate sense
// R5 - Polarity zero means active low gates
// R6 - Either fault input disables gates at once
// R7 - Unused fault input tied to inactive level
// R8 - Fault latches until host clear bit written
// R9 - Latched fault drives gates to fault levels
// R10 - Fault status pin copies internal fault flag
// R11 - Bridge on only while its comparators low
// R12 - Three-phase ignores first pair; two-phase separate
// R13 - Phase values: two at 90, three at 120
// R14 - Programmable PWM frequency and dead time
// R15 - Fault inputs sampled; flag sets first cycle
// R16 - Clear ignored while a fault input active
module bgc_gate_ctrl (
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// Host serial data line sharing.
	input  wire logic                    own_chip_select_n,
	input  wire logic                    own_serial_out,
	input  wire logic                    companion_chip_select_n,
	input  wire logic                    companion_serial_out_in,
	output logic                         host_serial_out,
	output logic                         host_serial_oe,
	// Waveform and timing configuration.
	input  wire logic                    three_phase_mode,
	input  wire logic [`BGC_PWM_W-1:0]   phase_a_value,
	input  wire logic [`BGC_PWM_W-1:0]   phase_b_value,
	input  wire logic [`BGC_PWM_W-1:0]   phase_c_value,
	input  wire logic [`BGC_PWM_W-1:0]   pwm_period,
	input  wire logic [`BGC_PRESC_W-1:0] pwm_prescale,
	input  wire logic [`BGC_DEAD_W-1:0]  dead_time,
	// Gate polarity and fault levels.
	input  wire logic                    high_side_polarity,
	input  wire logic                    low_side_polarity,
	input  wire logic                    fault_high_side_level,
	input  wire logic                    fault_low_side_level,
	// Overcurrent.
	input  wire logic                    fault_in_active_high,
	input  wire logic                    fault_in_active_low,
	input  wire logic                    fault_clear,
	output logic                         fault_status_out,
	// Current comparators, index 0 is the first phase pair.
	input  wire logic [`BGC_BRIDGES-1:0] phase_compare_pos,
	input  wire logic [`BGC_BRIDGES-1:0] phase_compare_neg,
	// Gate outputs at pin level.
	output logic      [`BGC_BRIDGES-1:0] gate_high,
	output logic      [`BGC_BRIDGES-1:0] gate_low,
	output logic                         pwm_cycle_start
);

	// ------------------------------------------------------------------
	// Host data line sharing
	// ------------------------------------------------------------------
	// This is a plain mux on the serial path. Putting it through flops
	// would skew the host's shift timing, so it stays combinational.
	always_comb begin
		if (!companion_chip_select_n) begin
			host_serial_out = companion_serial_out_in; // see R1, R2
		end else begin
			host_serial_out = own_serial_out; // see R1
		end
		host_serial_oe = !companion_chip_select_n || !own_chip_select_n;
	end

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0]               fault_pins_sync;
	logic [3:0]               level_pins_sync;
	logic [`BGC_BRIDGES-1:0]  cmp_pos_sync;
	logic [`BGC_BRIDGES-1:0]  cmp_neg_sync;

	// The active-low fault pin idles high; reset it there.
	bgc_sync2 #(
		.WIDTH   (2),
		.RST_VAL (2'b10)
	) u_sync_fault (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.async_in ({fault_in_active_low, fault_in_active_high}),
		.sync_out (fault_pins_sync)
	);

	bgc_sync2 #(
		.WIDTH   (4),
		.RST_VAL (4'h0)
	) u_sync_level (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.async_in ({fault_low_side_level, fault_high_side_level,
		            low_side_polarity, high_side_polarity}),
		.sync_out (level_pins_sync)
	);

	bgc_sync2 #(
		.WIDTH   (2 * `BGC_BRIDGES),
		.RST_VAL (8'h00)
	) u_sync_cmp (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.async_in ({phase_compare_neg, phase_compare_pos}),
		.sync_out ({cmp_neg_sync, cmp_pos_sync})
	);

	logic hs_pol;
	logic ls_pol;
	logic hs_fault_lvl;
	logic ls_fault_lvl;

	assign hs_pol       = level_pins_sync[0];
	assign ls_pol       = level_pins_sync[1];
	assign hs_fault_lvl = level_pins_sync[2];
	assign ls_fault_lvl = level_pins_sync[3];

	// ------------------------------------------------------------------
	// Overcurrent latch
	// ------------------------------------------------------------------
	logic fault_active;
	logic fault_reg;
	logic fault_next;

	always_comb begin
		// Either sense asserts; an unused pin tied inactive never does.
		fault_active = fault_pins_sync[0] || !fault_pins_sync[1]; // see R6, R7, R15
		// Set wins over clear, so a clear during an active input is void.
		fault_next   = fault_active || (fault_reg && !fault_clear); // see R8, R16
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fault_reg <= `BGC_FLAG_RST;
		end else begin
			fault_reg <= fault_next; // see R15
		end
	end

	assign fault_status_out = fault_reg; // see R10

	// ------------------------------------------------------------------
	// PWM carrier
	// ------------------------------------------------------------------
	logic [`BGC_PRESC_W-1:0] presc_reg;
	logic [`BGC_PRESC_W-1:0] presc_next;
	logic                    pwm_tick;
	logic [`BGC_PWM_W-1:0]   cnt_reg;
	logic [`BGC_PWM_W-1:0]   cnt_next;
	logic                    start_reg;
	logic                    start_next;

	// The prescaler divides the clock into a count enable; together with
	// the period it sets the PWM frequency.
	always_comb begin
		pwm_tick   = (presc_reg >= pwm_prescale);
		presc_next = pwm_tick ? `BGC_PRESC_RST : presc_reg + `BGC_PRESC_ONE;
		cnt_next   = cnt_reg;
		start_next = 1'b0;
		if (pwm_tick) begin
			if (cnt_reg >= pwm_period) begin
				cnt_next   = `BGC_PWM_CNT_RST; // see R14
				start_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + `BGC_CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			presc_reg <= `BGC_PRESC_RST;
			cnt_reg   <= `BGC_PWM_CNT_RST;
			start_reg <= 1'b0;
		end else begin
			presc_reg <= presc_next;
			cnt_reg   <= cnt_next;
			start_reg <= start_next;
		end
	end

	assign pwm_cycle_start = start_reg;

	// ------------------------------------------------------------------
	// Current chopping
	// ------------------------------------------------------------------
	// Group 0 is the Y phase, group 1 the X phase; in three-phase mode
	// group 0 carries the shared decision for all three bridges.
	logic [`BGC_BRIDGES-1:0] cmp_any;
	logic [`BGC_GROUPS-1:0]  chop_set;
	logic [`BGC_GROUPS-1:0]  chop_reg;
	logic [`BGC_GROUPS-1:0]  chop_next;

	always_comb begin
		cmp_any = cmp_pos_sync | cmp_neg_sync; // see R11
		if (three_phase_mode) begin
			chop_set[0] = cmp_any[`BGC_BR_Y1_W] || cmp_any[`BGC_BR_X2_V]
			              || cmp_any[`BGC_BR_X1_U]; // see R12
			chop_set[1] = chop_set[0];
		end else begin
			chop_set[0] = cmp_any[`BGC_BR_Y2] || cmp_any[`BGC_BR_Y1_W]; // see R12
			chop_set[1] = cmp_any[`BGC_BR_X2_V] || cmp_any[`BGC_BR_X1_U];
		end
		// The chop holds for the rest of the PWM cycle to stop the bridge
		// chattering on comparator noise; a new trip still wins the restart.
		chop_next = chop_set | (start_reg ? {`BGC_GROUPS{1'b0}} : chop_reg);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			chop_reg <= {`BGC_GROUPS{1'b0}};
		end else begin
			chop_reg <= chop_next;
		end
	end

	// ------------------------------------------------------------------
	// Duty per bridge
	// ------------------------------------------------------------------
	// Phase values are two's complement; flipping the sign bit gives an
	// offset duty. Two-phase drives each winding between a bridge pair
	// with opposite duty, three-phase uses one bridge per phase.
	logic [`BGC_PWM_W-1:0]  duty_a;
	logic [`BGC_PWM_W-1:0]  duty_b;
	logic [`BGC_PWM_W-1:0]  duty_c;
	logic [`BGC_PWM_W-1:0]  duty [`BGC_BRIDGES];
	logic [`BGC_BRIDGES-1:0] bridge_used;
	logic [`BGC_BRIDGES-1:0] bridge_chop;

	always_comb begin
		duty_a = {~phase_a_value[`BGC_PWM_W-1], phase_a_value[`BGC_PWM_W-2:0]};
		duty_b = {~phase_b_value[`BGC_PWM_W-1], phase_b_value[`BGC_PWM_W-2:0]};
		duty_c = {~phase_c_value[`BGC_PWM_W-1], phase_c_value[`BGC_PWM_W-2:0]};
		if (three_phase_mode) begin
			duty[`BGC_BR_Y2]   = `BGC_PWM_CNT_RST;
			duty[`BGC_BR_Y1_W] = duty_c; // see R13
			duty[`BGC_BR_X2_V] = duty_b;
			duty[`BGC_BR_X1_U] = duty_a;
			bridge_used        = 4'he;
			bridge_chop        = {4{chop_reg[0]}};
		end else begin
			duty[`BGC_BR_Y2]   = ~duty_b; // see R13
			duty[`BGC_BR_Y1_W] = duty_b;
			duty[`BGC_BR_X2_V] = ~duty_a;
			duty[`BGC_BR_X1_U] = duty_a;
			bridge_used        = 4'hf;
			bridge_chop        = {{2{chop_reg[1]}}, {2{chop_reg[0]}}};
		end
	end

	// ------------------------------------------------------------------
	// Bridges and output stage
	// ------------------------------------------------------------------
	logic [`BGC_BRIDGES-1:0] high_on;
	logic [`BGC_BRIDGES-1:0] low_on;
	logic [`BGC_BRIDGES-1:0] gate_high_reg;
	logic [`BGC_BRIDGES-1:0] gate_high_next;
	logic [`BGC_BRIDGES-1:0] gate_low_reg;
	logic [`BGC_BRIDGES-1:0] gate_low_next;

	genvar gi;
	generate
		for (gi = 0; gi < `BGC_BRIDGES; gi++) begin : g_bridge
			logic en;
			logic want;

			// A chopped or faulted bridge has its half bridge switched off; a fault then sets its gates to the fault levels.
			assign en   = bridge_used[gi] && !bridge_chop[gi] && !fault_reg; // see R11, R6
			assign want = (cnt_reg < duty[gi]);

			bgc_half_bridge u_hb (
				.ref_clk   (ref_clk),
				.reset_n   (reset_n),
				.bridge_en (en),
				.want_high (want),
				.dead_time (dead_time),
				.high_on   (high_on[gi]),
				.low_on    (low_on[gi])
			);

			always_comb begin
				if (fault_reg || fault_active) begin
					gate_high_next[gi] = hs_fault_lvl; // see R9, R6
					gate_low_next[gi]  = ls_fault_lvl; // see R9
				end else begin
					// Polarity zero inverts the sense: active low.
					gate_high_next[gi] = hs_pol ? high_on[gi] : !high_on[gi]; // see R4, R5
					gate_low_next[gi]  = ls_pol ? low_on[gi] : !low_on[gi]; // see R4, R5
				end
			end
		end
	endgenerate

	// Gates come up both off with the polarity at reset: active low.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			gate_high_reg <= {`BGC_BRIDGES{`BGC_LVL_HIGH}};
			gate_low_reg  <= {`BGC_BRIDGES{`BGC_LVL_HIGH}};
		end else begin
			gate_high_reg <= gate_high_next;
			gate_low_reg  <= gate_low_next;
		end
	end

	assign gate_high = gate_high_reg;
	assign gate_low  = gate_low_reg;

endmodule

//--- dv/bgc_gate_ctrl_monitor.sv
// Port-level assertions for the gate control stage.
`timescale 1ns/1ps
`include "bgc_gate_consts.svh"

module bgc_gate_ctrl_monitor (
	input wire logic                    ref_clk,
	input wire logic                    reset_n,
	input wire logic                    own_chip_select_n,
	input wire logic                    companion_chip_select_n,
	input wire logic                    companion_serial_out_in,
	input wire logic                    host_serial_out,
	input wire logic                    host_serial_oe,
	input wire logic                    high_side_polarity,
	input wire logic                    low_side_polarity,
	input wire logic                    fault_high_side_level,
	input wire logic                    fault_low_side_level,
	input wire logic                    fault_in_active_high,
	input wire logic                    fault_in_active_low,
	input wire logic                    fault_clear,
	input wire logic                    fault_status_out,
	input wire logic [`BGC_BRIDGES-1:0] gate_high,
	input wire logic [`BGC_BRIDGES-1:0] gate_low
);
	logic [2:0] age_reg;
	logic [2:0] age_next;
	logic [3:0] act_h;
	logic [3:0] act_l;

	// Polarity pins pass two sync flops, so gate senses settle a few edges after reset.
	always_comb begin
		age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
		if (!reset_n)
			age_next = 3'h0;
	end
	always_ff @(posedge ref_clk) begin
		age_reg <= age_next;
	end
	assign act_h = gate_high ~^ {4{high_side_polarity}};
	assign act_l = gate_low ~^ {4{low_side_polarity}};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_SDO_COMPANION: assert property (
		!companion_chip_select_n |-> host_serial_out == companion_serial_out_in)
		else $error("Data line does not carry companion data.");
	AST_SDO_ENABLE: assert property (
		host_serial_oe == (!own_chip_select_n || !companion_chip_select_n))
		else $error("Data line enable wrong.");
	AST_SET_HIGH_IN: assert property (
		$rose(fault_in_active_high) |-> ##[2:3] fault_status_out)
		else $error("Fault flag late for high input.");
	AST_SET_LOW_IN: assert property (
		$fell(fault_in_active_low) |-> ##[2:3] fault_status_out)
		else $error("Fault flag late for low input.");
	AST_HOLD: assert property (
		fault_status_out && !fault_clear |=> fault_status_out)
		else $error("Fault flag dropped without clear.");
	AST_CLEAR: assert property (
		(!fault_in_active_high && fault_in_active_low)[*3] ##0 fault_clear |=> !fault_status_out)
		else $error("Clear did not release fault flag.");
	AST_NO_CLEAR: assert property (
		(fault_in_active_high || !fault_in_active_low)[*3] ##0 fault_clear |=> fault_status_out)
		else $error("Clear released flag with fault active.");
	AST_FAULT_GATES: assert property (
		fault_status_out |-> gate_high == {4{fault_high_side_level}}
		&& gate_low == {4{fault_low_side_level}}) else $error("Gates not at fault levels.");
	AST_EXCLUSIVE: assert property (
		age_reg == 3'h7 && !fault_status_out |-> (act_h & act_l) == 4'h0)
		else $error("Both gates of a bridge active.");
	AST_BREAK_MAKE: assert property (
		age_reg == 3'h7 && !fault_status_out && !$past(fault_status_out)
		|-> (act_h & $past(act_l)) == 4'h0 && (act_l & $past(act_h)) == 4'h0)
		else $error("Gate turned on without dead time.");
endmodule

bind bgc_gate_ctrl bgc_gate_ctrl_monitor u_monitor (
	.ref_clk, .reset_n, .own_chip_select_n, .companion_chip_select_n,
	.companion_serial_out_in, .host_serial_out, .host_serial_oe,
	.high_side_polarity, .low_side_polarity, .fault_high_side_level,
	.fault_low_side_level, .fault_in_active_high, .fault_in_active_low,
	.fault_clear, .fault_status_out, .gate_high, .gate_low
);

//--- dv/bgc_power_stage.sv
// Behavioural power stage: current comparators and shoot-through detector.
`timescale 1ns/1ps
`include "bgc_gate_consts.svh"

module bgc_power_stage (
	input  wire logic                    high_side_polarity,
	input  wire logic                    low_side_polarity,
	input  wire logic [`BGC_BRIDGES-1:0] gate_high,
	input  wire logic [`BGC_BRIDGES-1:0] gate_low,
	input  wire logic [7:0]              trip,
	output logic      [`BGC_BRIDGES-1:0] phase_compare_pos,
	output logic      [`BGC_BRIDGES-1:0] phase_compare_neg,
	output logic                         fault_n
);
	logic [3:0] short_ckt;

	// A comparator is high while its phase current is above target.
	assign phase_compare_pos = trip[3:0];
	assign phase_compare_neg = trip[7:4];
	// Both transistors on shorts the supply; the driver pulls its error line low.
	assign short_ckt = (gate_high ~^ {4{high_side_polarity}})
		& (gate_low ~^ {4{low_side_polarity}});
	assign fault_n = (short_ckt == 4'h0);
endmodule

//--- dv/bgc_gate_ctrl_tb.sv
// Self-checking bench for the gate control stage.
`timescale 1ns/1ps
`include "bgc_gate_consts.svh"

module bgc_gate_ctrl_tb;
	localparam logic [5:0]  SDO_ROWS [7]  = '{6'h27, 6'h29, 6'h1b, 6'h15, 6'h09, 6'h07, 6'h3c};
	localparam logic [16:0] CHOP_ROWS [7] = '{17'h000a5, 17'h00821, 17'h000a5, 17'h01084,
		17'h100e0, 17'h101e0, 17'h14000};
	logic       ref_clk                 = 1'b0;
	logic       reset_n                 = 1'b0;
	logic       own_chip_select_n       = 1'b1;
	logic       own_serial_out          = 1'b0;
	logic       companion_chip_select_n = 1'b1;
	logic       companion_serial_out_in = 1'b0;
	logic       host_serial_out;
	logic       host_serial_oe;
	logic       three_phase_mode        = 1'b0;
	logic [8:0] phase_a_value           = 9'h0ff;
	logic [8:0] phase_b_value           = 9'h0ff;
	logic [8:0] phase_c_value           = 9'h0ff;
	logic [8:0] pwm_period              = 9'h00f;
	logic [7:0] pwm_prescale            = 8'h00;
	logic [7:0] dead_time               = 8'h03;
	logic       high_side_polarity      = 1'b0;
	logic       low_side_polarity       = 1'b0;
	logic       fault_high_side_level   = 1'b0;
	logic       fault_low_side_level    = 1'b1;
	logic       fault_in_active_high    = 1'b0;
	logic       fault_in_active_low;
	logic       fault_clear             = 1'b0;
	logic       fault_status_out;
	logic [3:0] phase_compare_pos;
	logic [3:0] phase_compare_neg;
	logic [3:0] gate_high;
	logic [3:0] gate_low;
	logic       pwm_cycle_start;
	logic [7:0] trip                    = 8'h00;
	logic       st_hp                   = 1'b0;
	logic       st_lp                   = 1'b0;
	logic       arm                     = 1'b0;
	logic       flo_n                   = 1'b1;
	logic       ps_fault_n;
	int         checked                 = 0;
	int         num_errors              = 0;

	// The stage error line is only heeded when armed: gates sit at reset level for a
	// few edges and would short an active-high stage before the polarity settles.
	assign fault_in_active_low = flo_n & (ps_fault_n | ~arm);
	always #20 ref_clk = ~ref_clk;

	bgc_gate_ctrl DUT (.ref_clk, .reset_n, .own_chip_select_n, .own_serial_out,
		.companion_chip_select_n, .companion_serial_out_in, .host_serial_out,
		.host_serial_oe, .three_phase_mode, .phase_a_value, .phase_b_value,
		.phase_c_value, .pwm_period, .pwm_prescale, .dead_time, .high_side_polarity,
		.low_side_polarity, .fault_high_side_level, .fault_low_side_level,
		.fault_in_active_high, .fault_in_active_low, .fault_clear, .fault_status_out,
		.phase_compare_pos, .phase_compare_neg, .gate_high, .gate_low, .pwm_cycle_start);
	bgc_power_stage u_stage (.high_side_polarity(st_hp), .low_side_polarity(st_lp),
		.gate_high, .gate_low, .trip, .phase_compare_pos, .phase_compare_neg,
		.fault_n(ps_fault_n));

	task automatic summarize();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_v(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_n(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			num_errors++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Events that a bounded wait can look for, by index.
	function automatic bit hit(input int sel);
		case (sel)
			0: return pwm_cycle_start === 1'b1;
			1: return fault_status_out === 1'b1;
			2: return gate_high[3] === 1'b0;
			default: return gate_low[3] === 1'b1;
		endcase
	endfunction
	task automatic wait_hi(input int sel, input int lim, output int n);
		string nm [4] = '{"pwm_cycle_start", "fault_status_out", "gate_high", "gate_low"};
		for (n = 0; n < lim && !hit(sel); n++)
			ticks(1);
		if (!hit(sel)) begin
			num_errors++;
			$display("[ERR] %s expected event seen none", nm[sel]);
			summarize();
		end
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		ticks(16);
		reset_n = 1'b1;
		ticks(1);
	endtask
	task automatic pulse_clear();
		fault_clear = 1'b1;
		ticks(1);
		fault_clear = 1'b0;
	endtask

	initial begin
		int          i;
		int          n;
		logic [16:0] r;
		logic [7:0]  ex;
		do_reset();
		cmp_v("fault_status_out", 8'h00, 8'(fault_status_out));
		for (i = 0; i < 7; i++) begin
			r[5:0] = SDO_ROWS[i];
			{own_chip_select_n, companion_chip_select_n, own_serial_out,
				companion_serial_out_in} = r[5:2];
			#1;
			if (r[0])
				cmp_v("host_serial_out", 8'(r[1]), 8'(host_serial_out));
			cmp_v("host_serial_oe", 8'(r[0]), 8'(host_serial_oe));
			ticks(1);
		end
		for (i = 0; i < 4; i++) begin
			{high_side_polarity, low_side_polarity} = 2'(i);
			{st_hp, st_lp} = 2'(i);
			do_reset();
			ticks(40);
			ex = {{2{high_side_polarity, ~high_side_polarity}},
				{2{~low_side_polarity, low_side_polarity}}};
			cmp_v("gates", ex, {gate_high, gate_low});
		end
		pwm_prescale = 8'h02;
		wait_hi(0, 100, n);
		ticks(1);
		wait_hi(0, 100, n);
		cmp_n("pwm period", 47, n);
		pwm_period = 9'h007;
		wait_hi(0, 100, n);
		ticks(1);
		wait_hi(0, 100, n);
		cmp_n("pwm period", 23, n);
		pwm_period = 9'h00f;
		pwm_prescale = 8'h00;
		for (i = 0; i < 2; i++) begin
			dead_time = i ? 8'h05 : 8'h00;
			phase_a_value = 9'h0ff;
			ticks(40);
			phase_a_value = 9'h100;
			wait_hi(2, 20, n);
			wait_hi(3, 20, n);
			cmp_n("dead time", i ? 5 : 1, n);
		end
		dead_time = 8'h03;
		phase_a_value = 9'h0ff;
		for (i = 0; i < 7; i++) begin
			r = CHOP_ROWS[i];
			{three_phase_mode, trip} = r[16:8];
			ticks(40);
			cmp_v("gates", r[7:0], {gate_high, gate_low});
		end
		{three_phase_mode, trip} = 9'h000;
		ticks(40);
		fault_in_active_high = 1'b1;
		wait_hi(1, 8, n);
		cmp_n("fault latency", 3, n);
		cmp_v("fault gates", 8'h0f, {gate_high, gate_low});
		fault_in_active_high = 1'b0;
		ticks(8);
		cmp_v("fault_status_out", 8'h01, 8'(fault_status_out));
		flo_n = 1'b0;
		ticks(3);
		pulse_clear();
		cmp_v("fault_status_out", 8'h01, 8'(fault_status_out));
		flo_n = 1'b1;
		ticks(3);
		pulse_clear();
		cmp_v("fault_status_out", 8'h00, 8'(fault_status_out));
		ticks(30);
		cmp_v("gates", 8'ha5, {gate_high, gate_low});
		st_lp = 1'b0;
		arm = 1'b1;
		wait_hi(1, 8, n);
		cmp_v("fault gates", 8'h0f, {gate_high, gate_low});
		st_lp = 1'b1;
		arm = 1'b0;
		ticks(3);
		pulse_clear();
		cmp_v("fault_status_out", 8'h00, 8'(fault_status_out));
		summarize();
	end
endmodule
